// File: iepf_core_model.sv
// Core-side model: takes enabled pending interrupts, lowest number first
`timescale 1ns/100ps
module iepf_core_model #(
	parameter int LAT = 3
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	input  wire logic        i_go,
	input  wire logic [63:0] i_enables,
	input  wire logic [63:0] i_pending,
	output logic      [63:0] o_pend_clear = '0
);
	wire [63:0] ready = i_enables & i_pending;
	int         wait_n = 0;
	// Slow on purpose: a service takes LAT+1 cycles
	always @(posedge i_core_clk) begin
		o_pend_clear <= '0;
		if (i_rst || !i_go || ready == 0)
			wait_n <= 0;
		else if (wait_n < LAT)
			wait_n <= wait_n + 1;
		else begin
			o_pend_clear <= ready & -ready;
			wait_n <= 0;
		end
	end
endmodule

// File: iepf_pkg.sv
// Package: register map, field layout and carrier types of the enable/pending/fast-vector slice
package iepf_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] OFF_GLOBAL_STATUS   = 12'h04c;
	localparam logic [11:0] OFF_FAST_SLOT2      = 12'h068;
	localparam logic [11:0] OFF_FAST_SLOT3      = 12'h06c;
	localparam logic [11:0] OFF_EN_SET_LOW      = 12'h100;
	localparam logic [11:0] OFF_EN_SET_HIGH     = 12'h104;
	localparam logic [11:0] OFF_EN_CLR_LOW      = 12'h180;
	localparam logic [11:0] OFF_EN_CLR_HIGH     = 12'h184;
	localparam logic [11:0] OFF_PEND_SET_LOW    = 12'h200;
	localparam logic [11:0] OFF_ENABLE_VIEW_LOW = 12'h800;
	localparam logic [11:0] OFF_ENABLE_VIEW_HI  = 12'h804;
	localparam logic [11:0] OFF_EVT_STATUS      = 12'h810;
	localparam logic [11:0] OFF_EVT_MASK        = 12'h814;

	// ----------------------------------------
	// Field positions and widths
	// ----------------------------------------
	localparam int IRQ_NUM_MSB     = 31;
	localparam int IRQ_NUM_LSB     = 24;
	localparam int ADDR_STORE_W    = 20;
	localparam int LOW_FIRST_IRQ   = 12;
	localparam int HIGH_FIRST_IRQ  = 32;
	localparam int HIGH_IRQ_COUNT  = 28;
	localparam int NUM_IRQS        = 64;
	localparam int GLOBAL_PEND_BIT = 9;

	// Writable bit masks per register
	localparam logic [31:0] MASK_LOW_RANGE = 32'hfffff000;
	localparam logic [31:0] MASK_HIGH      = 32'h0fffffff;
	localparam logic [31:0] MASK_PEND_LOW  = 32'hfffff00c;
	localparam logic [1:0]  MASK_EVT       = 2'h3;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0]  RST_IRQ_NUM  = 8'h00;
	localparam logic [19:0] RST_ADDR     = 20'h00000;
	localparam logic [63:0] RST_ENABLES  = 64'h0;
	localparam logic [63:0] RST_PENDING  = 64'h0;
	localparam logic [1:0]  RST_EVT      = 2'h0;

	// Event bit positions in status and mask
	localparam int EVT_PEND_SET_BIT = 0;
	localparam int EVT_ENABLE_BIT   = 1;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [7:0]  irq_num;
		logic [19:0] handler_addr;
	} iepf_fast_slot_type;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [11:0] adr;
		logic [31:0] dat;
	} iepf_wb_req_type;

	typedef struct packed {
		iepf_fast_slot_type slot2;
		iepf_fast_slot_type slot3;
		logic [63:0]        enables;
		logic [63:0]        pending;
		logic [1:0]         evt_status;
		logic [1:0]         evt_mask;
		logic               ack;
		logic [31:0]        rdata;
		logic               irq;
		logic               any_pend;
	} iepf_state_type;

endpackage

// File: iepf_regs.sv
// Module: enable, pending-set and fast-vector register slice on a classic Wishbone slave
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/100ps
// Notes on behaviour
// - Fast slots 2 and 3 hold a read/write 8-bit interrupt number in [31:24], reset zero.
// - Fast slots hold the handler address low bits in [19:0], read/write, reset zero.
// - Only address bits 19..0 are stored; bits 23..20 always read zero.
// - Enable-set low: a one in bits 31..12 enables that interrupt; zero does nothing.
// - Enable-set high: ones in bits 27..0 enable interrupts 32..59; 31..28 reserved.
// - Enable-clear low: a one in bits 31..12 disables that interrupt; zero does nothing.
// - Enable-clear high: ones in bits 27..0 disable interrupts 32..59; zero does nothing.
// - Pending-set low: a one in bits 31..12 marks that interrupt pending.
// - Pending-set low bits 3..2 mark interrupts 2 and 3 pending; others reserved.
// - A read-only global flag shows whether any interrupt is pending.
module iepf_regs #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input  wire logic                  i_core_clk,
	input  wire logic                  i_rst,
	// Wishbone slave
	input  wire logic                  i_wb_cyc,
	input  wire logic                  i_wb_stb,
	input  wire logic                  i_wb_we,
	input  wire logic [3:0]            i_wb_sel,
	input  wire logic [ADDR_W-1:0]     i_wb_adr,
	input  wire logic [31:0]           i_wb_dat,
	output logic      [31:0]           o_wb_dat,
	output logic                       o_wb_ack,
	// Pending clear from the neighbouring slice
	input  wire logic [63:0]           i_pend_clear,
	// Controller-facing state
	output iepf_pkg::iepf_fast_slot_type o_fast_slot2,
	output iepf_pkg::iepf_fast_slot_type o_fast_slot3,
	output logic      [63:0]           o_irq_enables,
	output logic      [63:0]           o_irq_pending,
	output logic                       o_global_pending_flag,
	// Interrupt
	output logic                       o_irq
);

	iepf_pkg::iepf_state_type  st_r;
	iepf_pkg::iepf_state_type  st_nxt;
	iepf_pkg::iepf_wb_req_type req;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	// Enable view high word: interrupts 32..59 in bits 27..0
	function automatic logic [31:0] high_word(input logic [63:0] v);
		high_word = v[63:32] & iepf_pkg::MASK_HIGH;
	endfunction

	function automatic logic [31:0] slot_word(input iepf_pkg::iepf_fast_slot_type s);
		slot_word = {s.irq_num, 4'h0, s.handler_addr};
	endfunction

	assign req = '{cyc: i_wb_cyc, stb: i_wb_stb, we: i_wb_we, sel: i_wb_sel,
		adr: i_wb_adr[11:0], dat: i_wb_dat};

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic        take;
		logic        wr;
		logic [31:0] wd;
		logic [31:0] wm;
		logic [63:0] en_set;
		logic [63:0] en_clr;
		logic [63:0] pd_set;
		logic [1:0]  evt;
		logic [31:0] rd;
		st_nxt = st_r;
		take   = req.cyc && req.stb && !st_r.ack;
		wr     = take && req.we;
		wm     = lane_mask(req.sel);
		wd     = req.dat & wm;
		en_set = 64'h0;
		en_clr = 64'h0;
		pd_set = 64'h0;
		rd     = 32'h0;
		evt    = 2'h0;

		if (wr) begin
			if (req.adr == iepf_pkg::OFF_FAST_SLOT2) begin
				if (req.sel[3]) begin
					st_nxt.slot2.irq_num = req.dat[31:24];
				end
				st_nxt.slot2.handler_addr = (st_r.slot2.handler_addr & ~wm[19:0])
					| wd[19:0];
			end else if (req.adr == iepf_pkg::OFF_FAST_SLOT3) begin
				if (req.sel[3]) begin
					st_nxt.slot3.irq_num = req.dat[31:24];
				end
				st_nxt.slot3.handler_addr = (st_r.slot3.handler_addr & ~wm[19:0])
					| wd[19:0];
			end else if (req.adr == iepf_pkg::OFF_EN_SET_LOW) begin
				en_set[31:0] = wd & iepf_pkg::MASK_LOW_RANGE;
			end else if (req.adr == iepf_pkg::OFF_EN_SET_HIGH) begin
				en_set[63:32] = wd & iepf_pkg::MASK_HIGH;
			end else if (req.adr == iepf_pkg::OFF_EN_CLR_LOW) begin
				en_clr[31:0] = wd & iepf_pkg::MASK_LOW_RANGE;
			end else if (req.adr == iepf_pkg::OFF_EN_CLR_HIGH) begin
				en_clr[63:32] = wd & iepf_pkg::MASK_HIGH;
			end else if (req.adr == iepf_pkg::OFF_PEND_SET_LOW) begin
				pd_set[31:0] = wd & iepf_pkg::MASK_PEND_LOW;
			end else if (req.adr == iepf_pkg::OFF_EVT_MASK) begin
				st_nxt.evt_mask = (st_r.evt_mask & ~wm[1:0]) | (wd[1:0] & iepf_pkg::MASK_EVT);
			end
		end

		// Set wins over clear when both name the same interrupt in one write
		st_nxt.enables = (st_r.enables & ~en_clr) | en_set;
		// Pending set wins over a simultaneous clear from the neighbour
		st_nxt.pending = (st_r.pending & ~i_pend_clear) | pd_set;

		evt[iepf_pkg::EVT_PEND_SET_BIT] = |pd_set;
		evt[iepf_pkg::EVT_ENABLE_BIT]   = |en_set;
		// Write-one-to-clear, new events win over the clear
		if (wr && req.adr == iepf_pkg::OFF_EVT_STATUS) begin
			st_nxt.evt_status = st_r.evt_status & ~(wd[1:0] & iepf_pkg::MASK_EVT);
		end
		st_nxt.evt_status = st_nxt.evt_status | evt;

		// Reads: write-only registers and unmapped offsets answer zero
		if (req.adr == iepf_pkg::OFF_FAST_SLOT2) begin
			rd = slot_word(st_r.slot2);
		end else if (req.adr == iepf_pkg::OFF_FAST_SLOT3) begin
			rd = slot_word(st_r.slot3);
		end else if (req.adr == iepf_pkg::OFF_GLOBAL_STATUS) begin
			rd[iepf_pkg::GLOBAL_PEND_BIT] = st_r.any_pend;
		end else if (req.adr == iepf_pkg::OFF_ENABLE_VIEW_LOW) begin
			rd = st_r.enables[31:0];
		end else if (req.adr == iepf_pkg::OFF_ENABLE_VIEW_HI) begin
			rd = high_word(st_r.enables);
		end else if (req.adr == iepf_pkg::OFF_EVT_STATUS) begin
			rd[1:0] = st_r.evt_status;
		end else if (req.adr == iepf_pkg::OFF_EVT_MASK) begin
			rd[1:0] = st_r.evt_mask;
		end else begin
			rd = 32'h0;
		end

		st_nxt.ack   = take;
		st_nxt.rdata = (take && !req.we) ? rd : 32'h0;
		st_nxt.any_pend = |st_nxt.pending;
		st_nxt.irq   = |(st_nxt.evt_status & st_nxt.evt_mask);
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st_r <= '{
				slot2: '{irq_num: iepf_pkg::RST_IRQ_NUM, handler_addr: iepf_pkg::RST_ADDR},
				slot3: '{irq_num: iepf_pkg::RST_IRQ_NUM, handler_addr: iepf_pkg::RST_ADDR},
				enables: iepf_pkg::RST_ENABLES,
				pending: iepf_pkg::RST_PENDING,
				evt_status: iepf_pkg::RST_EVT,
				evt_mask: iepf_pkg::RST_EVT,
				ack: 1'b0,
				rdata: 32'h0,
				irq: 1'b0,
				any_pend: 1'b0
			};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_wb_dat              = st_r.rdata;
	assign o_wb_ack              = st_r.ack;
	assign o_fast_slot2          = st_r.slot2;
	assign o_fast_slot3          = st_r.slot3;
	assign o_irq_enables         = st_r.enables;
	assign o_irq_pending         = st_r.pending;
	assign o_global_pending_flag = st_r.any_pend;
	assign o_irq                 = st_r.irq;

endmodule

// File: iepf_regs_properties.sv
// Checker: bus answer timing and register effects of the slice
`timescale 1ns/100ps
module iepf_regs_properties (
	input wire logic        i_core_clk,
	input wire logic        i_rst,
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic        i_wb_we,
	input wire logic [3:0]  i_wb_sel,
	input wire logic [11:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [31:0] o_wb_dat,
	input wire logic        o_wb_ack,
	input wire logic [63:0] o_irq_enables,
	input wire logic [63:0] o_irq_pending,
	input wire logic        o_global_pending_flag
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	wire        tk = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	wire        wf = tk & i_wb_we & (i_wb_sel == 4'hf);
	wire        rd = o_wb_ack & ~i_wb_we;
	wire [31:0] d  = i_wb_dat;
	wire [63:0] en = o_irq_enables;
	wire [63:0] pd = o_irq_pending;
	ack_pulse_a: assert property (tk |=> o_wb_ack ##1 !o_wb_ack)
		else $error("ack not one cycle after request");
	flag_tracks_a: assert property (o_global_pending_flag == |pd)
		else $error("pending flag wrong");
	slot_top_zero_a: assert property (
		rd && i_wb_adr[11:4] == 8'h06 |-> o_wb_dat[23:20] == 4'h0)
		else $error("slot address top bits not zero");
	wo_read_zero_a: assert property (
		rd && i_wb_adr[11:8] inside {4'h1, 4'h2} |-> o_wb_dat == 32'h0)
		else $error("write-only read not zero");
	en_set_lo_a: assert property (
		wf && i_wb_adr == iepf_pkg::OFF_EN_SET_LOW |=> &(en[31:12] | ~$past(d[31:12])))
		else $error("low enable set lost");
	en_set_hi_a: assert property (
		wf && i_wb_adr == iepf_pkg::OFF_EN_SET_HIGH |=> &(en[59:32] | ~$past(d[27:0])))
		else $error("high enable set lost");
	en_clr_lo_a: assert property (
		wf && i_wb_adr == iepf_pkg::OFF_EN_CLR_LOW |=> (en[31:12] & $past(d[31:12])) == 0)
		else $error("low enable clear lost");
	en_clr_hi_a: assert property (
		wf && i_wb_adr == iepf_pkg::OFF_EN_CLR_HIGH |=> (en[59:32] & $past(d[27:0])) == 0)
		else $error("high enable clear lost");
	pend_set_a: assert property (
		wf && i_wb_adr == iepf_pkg::OFF_PEND_SET_LOW
		|=> &(pd[31:0] | ~$past(d & iepf_pkg::MASK_PEND_LOW)))
		else $error("pending set lost");
	en_hold_a: assert property (
		!(tk && i_wb_we && i_wb_adr[11:8] == 4'h1) |=> $stable(en))
		else $error("enables changed without a write");
	reserved_zero_a: assert property (
		(en & ~{iepf_pkg::MASK_HIGH, iepf_pkg::MASK_LOW_RANGE}) == 0
		&& (pd & ~{32'h0, iepf_pkg::MASK_PEND_LOW}) == 0)
		else $error("reserved bit set");
	cover property (wf && i_wb_adr == iepf_pkg::OFF_PEND_SET_LOW);
	cover property (rd && o_wb_dat != 0);
	cover property (en != 0 ##1 en == 0);
endmodule
bind iepf_regs iepf_regs_properties i_iepf_regs_properties (.*);

// File: testbench.sv
// Testbench: register slice over Wishbone with a core model consuming pending
`timescale 1ns/100ps
module testbench;
	logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, go = 0;
	logic [3:0]  sel = 0;
	logic [11:0] adr = 0;
	logic [31:0] wd = 0, rd, q, d;
	logic [63:0] clr, oen, opd, en = 0;
	logic        ack, irq, gpf;
	int          miscompares = 0, n_tests = 0, seed = 15717, i, k;
	logic [11:0] ea [4] = '{iepf_pkg::OFF_EN_SET_LOW, iepf_pkg::OFF_EN_SET_HIGH,
		iepf_pkg::OFF_EN_CLR_LOW, iepf_pkg::OFF_EN_CLR_HIGH};
	iepf_pkg::iepf_fast_slot_type s2, s3;
	initial forever #2.5 clk = ~clk;
	iepf_regs i_iepf_regs (.i_core_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_sel(sel), .i_wb_adr(adr), .i_wb_dat(wd), .o_wb_dat(rd),
		.o_wb_ack(ack), .i_pend_clear(clr), .o_fast_slot2(s2), .o_fast_slot3(s3),
		.o_irq_enables(oen), .o_irq_pending(opd), .o_global_pending_flag(gpf), .o_irq(irq));
	iepf_core_model i_iepf_core_model (.i_core_clk(clk), .i_rst(rst), .i_go(go),
		.i_enables(oen), .i_pending(opd), .o_pend_clear(clr));
	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Holds the request until ack is sampled, then one idle cycle
	task automatic wb(logic w, logic [11:0] a, logic [31:0] v, logic [3:0] s = 4'hf);
		int n;
		n = 0;
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wd <= v;
		sel <= s;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rd;
		cyc <= 0;
		stb <= 0;
		if (ack !== 1'b1) begin
			miscompares++;
			conclude();
		end
		@(posedge clk);
	endtask
	function automatic logic [63:0] nxt_en(logic [11:0] a, logic [31:0] v, logic [63:0] e);
		logic [63:0] lo, hi;
		lo = {32'h0, v & iepf_pkg::MASK_LOW_RANGE};
		hi = {v & iepf_pkg::MASK_HIGH, 32'h0};
		case (a)
			iepf_pkg::OFF_EN_SET_LOW:  return e | lo;
			iepf_pkg::OFF_EN_SET_HIGH: return e | hi;
			iepf_pkg::OFF_EN_CLR_LOW:  return e & ~lo;
			default:                   return e & ~hi;
		endcase
	endfunction
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		wb(0, iepf_pkg::OFF_FAST_SLOT2, 0);
		chk("slot2 reset", q, 0);
		chk("enables reset", oen, 0);
		wb(1, iepf_pkg::OFF_FAST_SLOT2, 32'hffffffff);
		wb(0, iepf_pkg::OFF_FAST_SLOT2, 0);
		chk("slot2 read", q, 32'hff0fffff);
		chk("slot2 out", s2, 28'hfffffff);
		wb(1, iepf_pkg::OFF_FAST_SLOT3, 32'ha5123456, 4'h8);
		wb(0, iepf_pkg::OFF_FAST_SLOT3, 0);
		chk("slot3 read", q, 32'ha5000000);
		chk("slot3 out", s3, 28'ha500000);
		wb(0, 12'h0f0, 0);
		chk("unmapped read", q, 0);
		// First four: all ones through every path, then random
		for (i = 0; i < 16; i++) begin
			k = (i < 4) ? i : ($random(seed) & 3);
			d = (i < 4) ? 32'hffffffff : $random(seed);
			wb(1, ea[k], d);
			en = nxt_en(ea[k], d, en);
			chk("enables", oen, en);
			wb(0, ea[k], 0);
			chk("write-only read", q, 0);
		end
		// Enable-set writes above raised only the enable event
		wb(0, iepf_pkg::OFF_EVT_STATUS, 0);
		chk("event status", q, 32'h2);
		wb(0, iepf_pkg::OFF_ENABLE_VIEW_LOW, 0);
		chk("enable view low", q, en[31:0]);
		wb(0, iepf_pkg::OFF_ENABLE_VIEW_HI, 0);
		chk("enable view high", q, {4'h0, en[59:32]});
		wb(1, iepf_pkg::OFF_EVT_MASK, 32'h1);
		wb(1, iepf_pkg::OFF_PEND_SET_LOW, 32'hffffffff);
		chk("pending", opd, {32'h0, iepf_pkg::MASK_PEND_LOW});
		chk("irq raised", irq, 1);
		wb(1, iepf_pkg::OFF_EVT_STATUS, 32'h1);
		chk("irq cleared", irq, 0);
		wb(1, iepf_pkg::OFF_EN_SET_LOW, 32'hffffffff);
		go <= 1;
		for (i = 0; i < 300 && opd[31:12] != 0; i++)
			@(posedge clk);
		chk("consumed", opd, 64'hc);
		wb(0, iepf_pkg::OFF_GLOBAL_STATUS, 0);
		chk("global flag", q, 32'h200);
		chk("flag out", gpf, 1);
		conclude();
	end
endmodule
